//--- hw/irq_accept_pkg.sv
// Behaviour
// - a raised request latch holds until accepted, reset, or cleared by an instruction.
// - acceptance takes 8 machine cycles after the current instruction completes.
// - maskable return ends maskable service; non-maskable return ends non-maskable service.
// - stack pointer is 16 bits, post-decremented on call, push and acceptance.
// - stack pointer pre-increments on return or pop; stack grows downward.
// - reset loads the stack pointer with 00FFH.
// - first acceptance step clears the master enable to block further interrupts.
// - acceptance clears the request latch of the accepted source.
// - acceptance pushes status word, PC high, PC low; stack pointer drops by 3.
// - the saved status word carries register bank selection and master enable.
// - after pushing, the PC is loaded from the source's vector table entry.
// - no maskable request is accepted while the master enable stays 0.
// - acceptance pushes only PC and status word, no general-purpose registers.
// - both returns restore PC and status word from stack, stack pointer rises by 3.
// - the soft trap instruction starts interrupt processing at once, second in priority only to the undefined opcode.
// - fetch from a missing address yields 0xFF, the soft trap opcode.
// - undefined opcode raises its interrupt at once, even during non-maskable service.
// - level fields encode 00 lowest to 11 highest; all reset to 0.
// - register 0x0FF4 holds levels of sources 23,22,21,20 in pairs 7:6 to 1:0.
// - register 0x0FF5 holds source 25 in 3:2, source 24 in 1:0; 7:4 unused.
// - a higher programmed level wins over lower levels regardless of basic priority.
// - at equal level the higher basic priority (lower source number) wins.
// - master enable 0 blocks all maskable sources; each enable flag gates its source.
package irq_accept_pkg;
   localparam int SRC_COUNT = 26;
   localparam int SRC_W = 5;
   localparam int FIRST_LATCH = 2;
   localparam int FIRST_MASKABLE = 4;
   localparam int FIRST_REG_LEVEL = 20;
   localparam int SECOND_REG_LEVEL = 24;
   localparam int LEVEL_W = 2;
   localparam logic [4:0] SRC_BAD_OPCODE = 5'h00;
   localparam logic [4:0] SRC_SOFT_TRAP = 5'h01;
   localparam logic [15:0] SP_RESET = 16'h00FF;
   localparam logic [7:0] SOFT_TRAP_OPCODE = 8'hFF;
   localparam logic [15:0] VECTOR_TOP = 16'hFFFE;
   localparam int PSW_IMF_BIT = 0;
   localparam int PSW_RBS_BIT = 1;
   localparam logic [2:0] ACCEPT_LAST_STEP = 3'h7;
   localparam logic [2:0] RETURN_LAST_STEP = 3'h4;
   localparam int ADR_W = 18;
   localparam logic [15:0] LVL_SRC20_23_IDX = 16'h0FF4;
   localparam logic [15:0] LVL_SRC24_25_IDX = 16'h0FF5;
   localparam logic [15:0] SEQ_STATUS_IDX = 16'h0FF6;
   localparam logic [ADR_W-1:0] LVL_SRC20_23_ADDR = {LVL_SRC20_23_IDX, 2'h0};
   localparam logic [ADR_W-1:0] LVL_SRC24_25_ADDR = {LVL_SRC24_25_IDX, 2'h0};
   localparam logic [ADR_W-1:0] SEQ_STATUS_ADDR = {SEQ_STATUS_IDX, 2'h0};
   localparam logic [7:0] LVL_RESET = 8'h00;
   localparam logic [7:0] LVL_SRC24_25_MASK = 8'h0F;
   localparam int STAT_SRC_LSB = 0;
   localparam int STAT_IMF_BIT = 5;
   localparam int STAT_BUSY_BIT = 6;
   localparam int STAT_NMI_BIT = 7;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ACCEPT, SEQ_RETURN} seq_state_type;
endpackage : irq_accept_pkg

//--- hw/interrupt_priority_accept_seq.sv
module interrupt_priority_accept_seq
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [irq_accept_pkg::ADR_W-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   input wire logic [irq_accept_pkg::SRC_COUNT-1:irq_accept_pkg::FIRST_LATCH] irqRaise,
   input wire logic [irq_accept_pkg::SRC_COUNT-1:irq_accept_pkg::FIRST_LATCH] latchClear,
   input wire logic [irq_accept_pkg::SRC_COUNT-1:irq_accept_pkg::FIRST_MASKABLE] sourceEnableFlag,
   input wire logic [31:0] lowerLevelFields,
   input wire logic eiExec,
   input wire logic diExec,
   input wire logic instrDone,
   input wire logic fetchStrobe,
   input wire logic fetchAddrValid,
   input wire logic [7:0] fetchOpcodeIn,
   input wire logic badOpcode,
   input wire logic maskableReturnExec,
   input wire logic nonmaskableReturnExec,
   input wire logic spDecrement,
   input wire logic spIncrement,
   input wire logic spLoad,
   input wire logic [15:0] spLoadValue,
   input wire logic [15:0] pcIn,
   input wire logic [7:0] pswIn,
   input wire logic regBankSelect,
   input wire logic [7:0] memRdata,
   output logic [7:0] fetchOpcode,
   output logic [15:0] stackPtr,
   output logic [15:0] memAddr,
   output logic memRead,
   output logic memWrite,
   output logic [7:0] memWdata,
   output logic pcLoad,
   output logic [15:0] pcLoadValue,
   output logic pswLoad,
   output logic [7:0] pswLoadValue,
   output logic masterIrqEnable,
   output logic abortInstr,
   output logic seqBusy,
   output logic [irq_accept_pkg::SRC_COUNT-1:irq_accept_pkg::FIRST_LATCH] requestLatch
);

   irq_accept_pkg::seq_state_type state_r;
   logic [2:0] step_r;
   logic [irq_accept_pkg::SRC_W-1:0] acceptSrc_r;
   logic [7:0] levelLow_r;
   logic [7:0] levelHigh_r;
   logic [7:0] vecLow_r;
   logic [7:0] popPcl_r;
   logic [7:0] popPch_r;
   logic badPend_r;
   logic softPend_r;
   logic nmiService_r;
   logic savedImf_r;
   logic [1:0] levelOf [irq_accept_pkg::SRC_COUNT];
   logic [irq_accept_pkg::SRC_COUNT-1:irq_accept_pkg::FIRST_MASKABLE] maskReady;
   logic maskFound;
   logic [irq_accept_pkg::SRC_W-1:0] maskIdx;
   logic [1:0] maskLvl;
   logic nmiFound;
   logic [irq_accept_pkg::SRC_W-1:0] nmiIdx;
   logic softEvent;
   logic busReq;
   logic idle;
   logic startAccept;
   logic [irq_accept_pkg::SRC_W-1:0] startSrc;
   logic acceptFirst;
   logic returnDone;
   logic [15:0] vecAddr;
   logic [7:0] savedPsw;

   assign idle = (state_r == irq_accept_pkg::SEQ_IDLE);
   assign busReq = wbCyc && wbStb && !wbAck;
   assign acceptFirst = (state_r == irq_accept_pkg::SEQ_ACCEPT) && (step_r == 3'h0);
   assign returnDone = (state_r == irq_accept_pkg::SEQ_RETURN) && (step_r == irq_accept_pkg::RETURN_LAST_STEP);
   // a fetch outside the memory map reads as the trap opcode and so becomes a soft trap
   assign softEvent = fetchStrobe && (!fetchAddrValid || fetchOpcodeIn == irq_accept_pkg::SOFT_TRAP_OPCODE);
   assign vecAddr = irq_accept_pkg::VECTOR_TOP - {10'h000, acceptSrc_r, 1'b0};
   // the enable is cleared in step 0, so the value pushed is the one held when the request was taken
   assign savedPsw = {pswIn[7:2], regBankSelect, savedImf_r};

   if (irq_accept_pkg::PSW_IMF_BIT != 0 || irq_accept_pkg::PSW_RBS_BIT != 1)
   begin : g_psw_check
      $error("status word packing assumes enable in bit 0 and bank select in bit 1");
   end

   // level fields: sources 4..19 come from the lower registers, 20..25 live here
   for (genvar i = 0; i < irq_accept_pkg::SRC_COUNT; i++)
   begin : g_level
      if (i < irq_accept_pkg::FIRST_MASKABLE)
      begin : g_none
         assign levelOf[i] = 2'h0;
      end
      else if (i < irq_accept_pkg::FIRST_REG_LEVEL)
      begin : g_low
         assign levelOf[i] = lowerLevelFields[2*(i-irq_accept_pkg::FIRST_MASKABLE) +: 2];
      end
      else if (i < irq_accept_pkg::SECOND_REG_LEVEL)
      begin : g_reg5
         assign levelOf[i] = levelLow_r[2*(i-irq_accept_pkg::FIRST_REG_LEVEL) +: 2];
      end
      else
      begin : g_reg6
         assign levelOf[i] = levelHigh_r[2*(i-irq_accept_pkg::SECOND_REG_LEVEL) +: 2];
      end
   end

   for (genvar i = irq_accept_pkg::FIRST_MASKABLE; i < irq_accept_pkg::SRC_COUNT; i++)
   begin : g_ready
      assign maskReady[i] = requestLatch[i] && sourceEnableFlag[i] && masterIrqEnable;
   end

   // walk downward with >= so the lowest-numbered source wins a level tie
   always_comb
   begin
      maskFound = 1'b0;
      maskIdx = '0;
      maskLvl = 2'h0;
      for (int i = irq_accept_pkg::SRC_COUNT - 1; i >= irq_accept_pkg::FIRST_MASKABLE; i--)
      begin
         if (maskReady[i] && (!maskFound || levelOf[i] >= maskLvl))
         begin
            maskFound = 1'b1;
            maskIdx = irq_accept_pkg::SRC_W'(i);
            maskLvl = levelOf[i];
         end
      end
   end

   always_comb
   begin
      nmiFound = 1'b0;
      nmiIdx = '0;
      for (int i = irq_accept_pkg::FIRST_MASKABLE - 1; i >= irq_accept_pkg::FIRST_LATCH; i--)
      begin
         if (requestLatch[i])
         begin
            nmiFound = 1'b1;
            nmiIdx = irq_accept_pkg::SRC_W'(i);
         end
      end
   end

   // bad opcode and soft trap do not wait for an instruction boundary
   always_comb
   begin
      startAccept = 1'b0;
      startSrc = irq_accept_pkg::SRC_BAD_OPCODE;
      if (badPend_r || badOpcode)
      begin
         startAccept = 1'b1;
      end
      else if (softPend_r || softEvent)
      begin
         startAccept = 1'b1;
         startSrc = irq_accept_pkg::SRC_SOFT_TRAP;
      end
      else if (instrDone && nmiFound)
      begin
         startAccept = 1'b1;
         startSrc = nmiIdx;
      end
      else if (instrDone && maskFound)
      begin
         startAccept = 1'b1;
         startSrc = maskIdx;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r <= irq_accept_pkg::SEQ_IDLE;
         step_r <= 3'h0;
         acceptSrc_r <= '0;
         savedImf_r <= 1'b0;
      end
      else if (idle)
      begin
         step_r <= 3'h0;
         if (startAccept)
         begin
            state_r <= irq_accept_pkg::SEQ_ACCEPT;
            acceptSrc_r <= startSrc;
            savedImf_r <= masterIrqEnable;
         end
         else if (maskableReturnExec || nonmaskableReturnExec)
         begin
            state_r <= irq_accept_pkg::SEQ_RETURN;
         end
      end
      else if ((state_r == irq_accept_pkg::SEQ_ACCEPT && step_r == irq_accept_pkg::ACCEPT_LAST_STEP) || returnDone)
      begin
         state_r <= irq_accept_pkg::SEQ_IDLE;
         step_r <= 3'h0;
      end
      else
      begin
         step_r <= step_r + 3'h1;
      end
   end

   // a trap seen in idle is taken at once; only one that cannot start now waits here
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         badPend_r <= 1'b0;
         softPend_r <= 1'b0;
      end
      else
      begin
         if (badOpcode && !idle)
            badPend_r <= 1'b1;
         else if (idle)
            badPend_r <= 1'b0;
         if (softEvent && !(idle && !badPend_r && !badOpcode))
            softPend_r <= 1'b1;
         else if (idle && !badPend_r && !badOpcode)
            softPend_r <= 1'b0;
      end
   end

   for (genvar i = irq_accept_pkg::FIRST_LATCH; i < irq_accept_pkg::SRC_COUNT; i++)
   begin : g_latch
      always_ff @(posedge clk)
      begin
         if (reset)
            requestLatch[i] <= 1'b0;
         else if (irqRaise[i])
            requestLatch[i] <= 1'b1;
         else if (latchClear[i] || (acceptFirst && acceptSrc_r == irq_accept_pkg::SRC_W'(i)))
            requestLatch[i] <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         masterIrqEnable <= 1'b0;
      else if (acceptFirst)
         masterIrqEnable <= 1'b0;
      else if (returnDone)
         masterIrqEnable <= memRdata[irq_accept_pkg::PSW_IMF_BIT];
      else if (eiExec)
         masterIrqEnable <= 1'b1;
      else if (diExec)
         masterIrqEnable <= 1'b0;
   end

   // load, decrement and increment requests are honoured only between sequences
   always_ff @(posedge clk)
   begin
      if (reset)
         stackPtr <= irq_accept_pkg::SP_RESET;
      else if (state_r == irq_accept_pkg::SEQ_ACCEPT && step_r >= 3'h1 && step_r <= 3'h3)
         stackPtr <= stackPtr - 16'h0001;
      else if (state_r == irq_accept_pkg::SEQ_RETURN && step_r <= 3'h2)
         stackPtr <= stackPtr + 16'h0001;
      else if (idle && spLoad)
         stackPtr <= spLoadValue;
      else if (idle && spDecrement)
         stackPtr <= stackPtr - 16'h0001;
      else if (idle && spIncrement)
         stackPtr <= stackPtr + 16'h0001;
   end

   // memory port: pushes write at the pointer, pops read one above it
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         memAddr <= 16'h0000;
         memRead <= 1'b0;
         memWrite <= 1'b0;
         memWdata <= 8'h00;
      end
      else
      begin
         memRead <= 1'b0;
         memWrite <= 1'b0;
         if (state_r == irq_accept_pkg::SEQ_ACCEPT)
         begin
            unique case (step_r)
               3'h1:
               begin
                  memWrite <= 1'b1;
                  memAddr <= stackPtr;
                  memWdata <= savedPsw;
               end
               3'h2:
               begin
                  memWrite <= 1'b1;
                  memAddr <= stackPtr;
                  memWdata <= pcIn[15:8];
               end
               3'h3:
               begin
                  memWrite <= 1'b1;
                  memAddr <= stackPtr;
                  memWdata <= pcIn[7:0];
               end
               3'h4:
               begin
                  memRead <= 1'b1;
                  memAddr <= vecAddr;
               end
               3'h5:
               begin
                  memRead <= 1'b1;
                  memAddr <= vecAddr + 16'h0001;
               end
               default:
               begin
               end
            endcase
         end
         else if (state_r == irq_accept_pkg::SEQ_RETURN && step_r <= 3'h2)
         begin
            memRead <= 1'b1;
            memAddr <= stackPtr + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         vecLow_r <= 8'h00;
         popPcl_r <= 8'h00;
         popPch_r <= 8'h00;
      end
      else
      begin
         if (state_r == irq_accept_pkg::SEQ_ACCEPT && step_r == 3'h6)
            vecLow_r <= memRdata;
         if (state_r == irq_accept_pkg::SEQ_RETURN && step_r == 3'h2)
            popPcl_r <= memRdata;
         if (state_r == irq_accept_pkg::SEQ_RETURN && step_r == 3'h3)
            popPch_r <= memRdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pcLoad <= 1'b0;
         pcLoadValue <= 16'h0000;
         pswLoad <= 1'b0;
         pswLoadValue <= 8'h00;
      end
      else
      begin
         pcLoad <= 1'b0;
         pswLoad <= 1'b0;
         if (state_r == irq_accept_pkg::SEQ_ACCEPT && step_r == irq_accept_pkg::ACCEPT_LAST_STEP)
         begin
            pcLoad <= 1'b1;
            pcLoadValue <= {memRdata, vecLow_r};
         end
         else if (returnDone)
         begin
            pcLoad <= 1'b1;
            pcLoadValue <= {popPch_r, popPcl_r};
            pswLoad <= 1'b1;
            pswLoadValue <= memRdata;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         fetchOpcode <= 8'h00;
         abortInstr <= 1'b0;
         seqBusy <= 1'b0;
      end
      else
      begin
         if (fetchStrobe)
            fetchOpcode <= fetchAddrValid ? fetchOpcodeIn : irq_accept_pkg::SOFT_TRAP_OPCODE;
         abortInstr <= badOpcode;
         seqBusy <= !idle || startAccept || maskableReturnExec || nonmaskableReturnExec;
      end
   end

   // tracks whether a non-maskable handler is running; only visible in status
   always_ff @(posedge clk)
   begin
      if (reset)
         nmiService_r <= 1'b0;
      else if (acceptFirst && acceptSrc_r < irq_accept_pkg::SRC_W'(irq_accept_pkg::FIRST_MASKABLE))
         nmiService_r <= 1'b1;
      else if (idle && nonmaskableReturnExec && !startAccept)
         nmiService_r <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         levelLow_r <= irq_accept_pkg::LVL_RESET;
         levelHigh_r <= irq_accept_pkg::LVL_RESET;
      end
      else if (busReq && wbWe && wbSel[0])
      begin
         if (wbAdr == irq_accept_pkg::LVL_SRC20_23_ADDR)
            levelLow_r <= wbDatW[7:0];
         else if (wbAdr == irq_accept_pkg::LVL_SRC24_25_ADDR)
            levelHigh_r <= wbDatW[7:0] & irq_accept_pkg::LVL_SRC24_25_MASK;
      end
   end

   // every address acks; unmapped reads return zero and unmapped writes are dropped
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wbAck <= 1'b0;
         wbDatR <= 32'h00000000;
      end
      else
      begin
         wbAck <= busReq;
         wbDatR <= 32'h00000000;
         if (busReq && !wbWe)
         begin
            if (wbAdr == irq_accept_pkg::LVL_SRC20_23_ADDR)
               wbDatR[7:0] <= levelLow_r;
            else if (wbAdr == irq_accept_pkg::LVL_SRC24_25_ADDR)
               wbDatR[7:0] <= levelHigh_r;
            else if (wbAdr == irq_accept_pkg::SEQ_STATUS_ADDR)
            begin
               wbDatR[irq_accept_pkg::STAT_SRC_LSB +: irq_accept_pkg::SRC_W] <= acceptSrc_r;
               wbDatR[irq_accept_pkg::STAT_IMF_BIT] <= masterIrqEnable;
               wbDatR[irq_accept_pkg::STAT_BUSY_BIT] <= !idle;
               wbDatR[irq_accept_pkg::STAT_NMI_BIT] <= nmiService_r;
            end
         end
      end
   end

endmodule : interrupt_priority_accept_seq

//--- tb/irq_accept_asserts.sv
module irq_accept_asserts
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbAck,
   input wire logic badOpcode,
   input wire logic fetchStrobe,
   input wire logic fetchAddrValid,
   input wire logic [7:0] fetchOpcode,
   input wire logic abortInstr,
   input wire logic [15:0] stackPtr,
   input wire logic [15:0] memAddr,
   input wire logic memRead,
   input wire logic memWrite,
   input wire logic pcLoad,
   input wire logic pswLoad,
   input wire logic masterIrqEnable,
   input wire logic [irq_accept_pkg::SRC_COUNT-1:irq_accept_pkg::FIRST_LATCH] requestLatch,
   input wire logic [irq_accept_pkg::SRC_COUNT-1:irq_accept_pkg::FIRST_LATCH] latchClear
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence push3;
      memWrite ##1 (memWrite && memAddr == $past(memAddr) - 16'h1) ##1 (memWrite && memAddr == $past(memAddr) - 16'h1);
   endsequence
   sequence fetch2;
      memRead ##1 (memRead && memAddr == $past(memAddr) + 16'h1);
   endsequence
   sequence pop3;
      fetch2 ##1 (memRead && memAddr == $past(memAddr) + 16'h1);
   endsequence
   a_sp_reset: assert property ($fell(reset) |-> stackPtr == 16'h00FF) else $error("stack pointer not reset");
   a_push_order: assert property ($rose(memWrite) |-> push3 ##1 !memWrite) else $error("bad push run");
   a_push_imf: assert property (memWrite |-> !masterIrqEnable) else $error("push with master enable");
   a_sp_drop: assert property ($rose(memWrite) ##3 1 |-> stackPtr == $past(memAddr, 3) - 16'h3)
      else $error("stack pointer not down by 3");
   a_vector_fetch: assert property ($fell(memWrite) |-> fetch2 ##2 (pcLoad && !pswLoad))
      else $error("vector load out of step");
   a_ret_pop: assert property ($rose(memRead) && !$past(memWrite) |-> pop3 ##[1:4] (pcLoad && pswLoad))
      else $error("return pop out of step");
   a_fetch_trap: assert property (fetchStrobe && !fetchAddrValid |=> fetchOpcode == 8'hFF)
      else $error("missing address not trapped");
   a_bad_abort: assert property (badOpcode |=> abortInstr) else $error("no abort on bad opcode");
   a_latch_hold: assert property (!$past(reset) && |($past(requestLatch) & ~requestLatch & ~$past(latchClear))
      |-> ##[1:3] memWrite) else $error("latch dropped without acceptance");
   a_ack_once: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck) else $error("bus ack not one pulse");
endmodule : irq_accept_asserts

bind interrupt_priority_accept_seq irq_accept_asserts irq_accept_asserts_inst (.clk, .reset, .wbCyc, .wbStb, .wbAck,
   .badOpcode, .fetchStrobe, .fetchAddrValid, .fetchOpcode, .abortInstr, .stackPtr, .memAddr, .memRead, .memWrite,
   .pcLoad, .pswLoad, .masterIrqEnable, .requestLatch, .latchClear);

//--- tb/stack_mem_model.sv
module stack_mem_model
(
   input wire logic clk,
   input wire logic [15:0] memAddr,
   input wire logic memRead,
   input wire logic memWrite,
   input wire logic [7:0] memWdata,
   output logic [7:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [int];
   logic [7:0] wrLog [256];
   int wrCount = 0;
   initial memRdata = 8'h00;
   always @(posedge clk)
   begin
      if (memWrite)
      begin
         mem[memAddr] = memWdata;
         wrLog[wrCount[7:0]] = memWdata;
         wrCount = wrCount + 1;
      end
      // unwritten places answer a pattern from the address, so vectors are predictable
      if (memRead)
         memRdata <= mem.exists(memAddr) ? mem[memAddr] : memAddr[7:0] ^ 8'hA5;
      else
         memRdata <= ~memRdata;
   end
endmodule : stack_mem_model

//--- tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, fetchAddrValid = 1'b1, regBankSelect = 1'b0;
   logic [17:0] wbAdr = 18'h0;
   logic [3:0] wbSel = 4'hF;
   logic [31:0] wbDatW = 32'h0, lowerLevelFields = 32'h0, wbDatR;
   // pulses: instr done, fetch, bad opcode, maskable ret, nonmaskable ret, ei, di, sp dec, sp inc, sp load
   logic [9:0] pulse = 10'h0;
   logic [25:2] irqRaise = 24'h0, latchClear = 24'h0, requestLatch;
   logic [25:4] sourceEnableFlag = 22'h3FFFFF;
   logic [7:0] fetchOpcodeIn = 8'h00, pswIn = 8'hB4, memRdata, fetchOpcode, memWdata, pswLoadValue;
   logic [15:0] spLoadValue = 16'h023F, pcIn = 16'h1234, stackPtr, memAddr, pcLoadValue;
   logic wbAck, memRead, memWrite, pcLoad, pswLoad, masterIrqEnable, abortInstr, seqBusy;
   int errors = 0, comparisons = 0, cycles = 0;
   interrupt_priority_accept_seq interrupt_priority_accept_seq_inst (.clk, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr,
      .wbSel, .wbDatW, .wbDatR, .wbAck, .irqRaise, .latchClear, .sourceEnableFlag, .lowerLevelFields,
      .eiExec(pulse[5]), .diExec(pulse[6]), .instrDone(pulse[0]), .fetchStrobe(pulse[1]), .fetchAddrValid,
      .fetchOpcodeIn, .badOpcode(pulse[2]), .maskableReturnExec(pulse[3]), .nonmaskableReturnExec(pulse[4]),
      .spDecrement(pulse[7]), .spIncrement(pulse[8]), .spLoad(pulse[9]), .spLoadValue, .pcIn, .pswIn,
      .regBankSelect, .memRdata, .fetchOpcode, .stackPtr, .memAddr, .memRead, .memWrite, .memWdata, .pcLoad,
      .pcLoadValue, .pswLoad, .pswLoadValue, .masterIrqEnable, .abortInstr, .seqBusy, .requestLatch);
   stack_mem_model stack_mem_model_inst (.clk, .memAddr, .memRead, .memWrite, .memWdata, .memRdata);
   always #4 clk = ~clk;
   task summarize;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         errors++;
         summarize();
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task wbAccess(input logic we, input logic [17:0] a, input logic [7:0] d, input logic [3:0] s,
      output logic [31:0] rd);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= s;
      wbDatW <= {24'h0, d};
      do @(posedge clk); while (wbAck !== 1'b1 && cycles < 4000);
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask : wbAccess
   task regCheck(input logic [17:0] a, input logic [7:0] d, input logic [3:0] sel, input logic [7:0] exp);
      logic [31:0] rd;
      wbAccess(1'b1, a, d, sel, rd);
      wbAccess(1'b0, a, 8'h00, 4'hF, rd);
      check(rd, {24'h0, exp});
   endtask : regCheck
   task fire(input int k);
      @(posedge clk);
      pulse[k] <= 1'b1;
      @(posedge clk);
      pulse <= 10'h0;
   endtask : fire
   task raise(input logic [25:2] bits);
      irqRaise <= bits;
      @(posedge clk);
      irqRaise <= 24'h0;
   endtask : raise
   function logic [15:0] vec(input int src);
      logic [15:0] va;
      va = 16'hFFFE - 16'(2 * src);
      return {(va[7:0] | 8'h01) ^ 8'hA5, va[7:0] ^ 8'hA5};
   endfunction : vec
   task doAccept(input int kind, input int src, input logic master_irq_enable);
      int n;
      int w;
      logic [15:0] sp0;
      logic aborted;
      sp0 = stackPtr;
      w = stack_mem_model_inst.wrCount;
      fire(kind);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (n == 1)
            aborted = abortInstr;
      end
      while (pcLoad !== 1'b1 && n < 40);
      check(n, 9);
      check(pcLoadValue, vec(src));
      check(stackPtr, sp0 - 16'h3);
      check(stack_mem_model_inst.wrCount - w, 3);
      check(stack_mem_model_inst.wrLog[w], {pswIn[7:2], regBankSelect, master_irq_enable});
      check(stack_mem_model_inst.wrLog[w + 1], pcIn[15:8]);
      check(stack_mem_model_inst.wrLog[w + 2], pcIn[7:0]);
      check(masterIrqEnable, 1'b0);
      check(seqBusy, 1'b1);
      if (src >= 2)
         check(requestLatch[src], 1'b0);
      if (kind == 2)
         check(aborted, 1'b1);
      if (kind == 1)
         check(fetchOpcode, 8'hFF);
   endtask : doAccept
   task doReturn(input int kind, input logic master_irq_enable);
      logic [15:0] sp0;
      sp0 = stackPtr;
      fire(kind);
      repeat (40) if (pcLoad !== 1'b1) @(posedge clk);
      check(pswLoad, 1'b1);
      check(pcLoadValue, pcIn);
      check(pswLoadValue, {pswIn[7:2], regBankSelect, master_irq_enable});
      check(stackPtr, sp0 + 16'h3);
      @(posedge clk);
      check(masterIrqEnable, master_irq_enable);
   endtask : doReturn
   task noAccept;
      fire(0);
      repeat (12)
      begin
         @(posedge clk);
         check(memWrite, 1'b0);
         check(seqBusy, 1'b0);
      end
   endtask : noAccept
   task t_regs;
      logic [31:0] rd;
      check(stackPtr, 16'h00FF);
      wbAccess(1'b0, irq_accept_pkg::LVL_SRC24_25_ADDR, 8'h00, 4'hF, rd);
      check(rd, 32'h0);
      regCheck(irq_accept_pkg::LVL_SRC20_23_ADDR, 8'hC6, 4'h0, 8'h00);
      regCheck(irq_accept_pkg::LVL_SRC20_23_ADDR, 8'hC6, 4'hF, 8'hC6);
      regCheck(irq_accept_pkg::LVL_SRC24_25_ADDR, 8'hFF, 4'hF, 8'h0F);
      regCheck(18'h00100, 8'hFF, 4'hF, 8'h00);
   endtask : t_regs
   task t_stack;
      fire(9);
      @(posedge clk);
      check(stackPtr, 16'h023F);
      fire(7);
      @(posedge clk);
      check(stackPtr, 16'h023E);
      fire(8);
      @(posedge clk);
      check(stackPtr, 16'h023F);
   endtask : t_stack
   task t_priority;
      regCheck(irq_accept_pkg::LVL_SRC20_23_ADDR, 8'h03, 4'hF, 8'h03);
      lowerLevelFields <= 32'h20;
      raise(24'h040014);
      fire(5);
      doAccept(0, 20, 1'b1);
      check(requestLatch[6], 1'b1);
      doReturn(3, 1'b1);
      doAccept(0, 6, 1'b1);
      doReturn(3, 1'b1);
      raise(24'h000008);
      doAccept(0, 4, 1'b1);
      noAccept();
      check(requestLatch[5], 1'b1);
      sourceEnableFlag[5] <= 1'b0;
      fire(5);
      @(posedge clk);
      check(masterIrqEnable, 1'b1);
      noAccept();
      fire(6);
      @(posedge clk);
      check(masterIrqEnable, 1'b0);
      latchClear <= 24'h000008;
      @(posedge clk);
      latchClear <= 24'h0;
      @(posedge clk);
      check(requestLatch[5], 1'b0);
   endtask : t_priority
   task t_nonmask;
      logic [31:0] rd;
      regBankSelect <= 1'b1;
      pcIn <= 16'hBE5A;
      fetchAddrValid <= 1'b0;
      doAccept(1, 1, 1'b0);
      fetchAddrValid <= 1'b1;
      doReturn(4, 1'b0);
      fetchOpcodeIn <= 8'hFF;
      doAccept(1, 1, 1'b0);
      fetchOpcodeIn <= 8'h00;
      doReturn(4, 1'b0);
      raise(24'h000001);
      doAccept(0, 2, 1'b0);
      doAccept(2, 0, 1'b0);
      wbAccess(1'b0, irq_accept_pkg::SEQ_STATUS_ADDR, 8'h00, 4'hF, rd);
      check(rd, 32'h00000080);
      doReturn(4, 1'b0);
      doReturn(4, 1'b0);
   endtask : t_nonmask
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_regs();
      t_stack();
      t_priority();
      t_nonmask();
      summarize();
   end
endmodule : tb_top
